// ---- verilog/slfr_pkg.sv ----
/*
 link control constants: register map, reset values, thresholds.
 assumes a single reference clock domain for all users.
*/
package slfr_pkg;
  localparam int NCH = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  // three-level select coding
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_MID = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  // amplitude trip points, arbitrary units
  localparam logic [7:0] AMP_LOW = 8'h20;
  localparam logic [7:0] AMP_MID = 8'h40;
  localparam logic [7:0] AMP_HIGH = 8'h80;
  // register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_LATCH = 8'h08;
  localparam logic [7:0] REG_DENSITY = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;
  // reset values
  localparam logic [7:0] OE_RST = 8'h00;
  localparam logic [7:0] BIST_RST = 8'hff;
  localparam logic [7:0] RX_RST = 8'h00;
  localparam logic [7:0] DENSITY_RST = 8'h3c;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [2:0] EB_NOMINAL = 3'h4;
  // settle length after reset release, below 16
  localparam logic [3:0] SETTLE_CYC = 4'h8;
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN = 3'b100
  } slfr_state_e;
endpackage : slfr_pkg

// ---- verilog/slfr_top.sv ----
/*
 per-channel loopback, signal detect, link fault and device reset logic.
 assumes tx_serial, rx_amplitude and freq_out_of_range come from logic
 on mclk; pins and latch enables are asynchronous.
*/
`timescale 1ns/1ps
module slfr_top #(
  parameter int NCH = slfr_pkg::NCH
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // asynchronous control pins
  input wire logic device_reset_n,
  input wire logic [1:0] detect_amplitude_select,
  input wire logic [3:0] loopback_enable,
  input wire logic [7:0] shared_enable_bits,
  input wire logic output_enable_latch_enable,
  input wire logic selftest_latch_enable,
  input wire logic receive_enable_latch_enable,
  // serial side
  input wire logic [3:0] tx_serial,
  input wire logic [3:0] rx_serial_in,
  input wire logic [31:0] rx_amplitude,
  input wire logic [3:0] freq_out_of_range,
  output logic [3:0] serial_out,
  output logic [3:0] serial_drive_en,
  output logic [3:0] cdr_data,
  // status
  output logic [3:0] link_fault_n,
  output logic [7:0] selftest_enable_n,
  output logic [3:0] rx_power_en,
  output logic [2:0] eb_wr_ptr,
  output logic [2:0] eb_rd_ptr,
  output logic device_ready,
  output logic irq,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  function automatic logic [7:0] amp_thr(input logic [1:0] sel);
    amp_thr = (sel == slfr_pkg::SEL_LOW) ? slfr_pkg::AMP_LOW :
              (sel == slfr_pkg::SEL_MID) ? slfr_pkg::AMP_MID :
              slfr_pkg::AMP_HIGH;
  endfunction : amp_thr

  // two-stage synchronizer for every asynchronous pin
  logic [21:0] sync1_q;
  logic [21:0] sync2_q;
  wire [21:0] pins = {
    device_reset_n, detect_amplitude_select, loopback_enable,
    shared_enable_bits, output_enable_latch_enable,
    selftest_latch_enable, receive_enable_latch_enable, rx_serial_in};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 22'h0;
      sync2_q <= 22'h0;
    end else if (ce) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  wire [3:0] rx_s = sync2_q[3:0];
  wire receive_enable_latch_enable_s = sync2_q[4];
  wire selftest_latch_enable_s = sync2_q[5];
  wire output_enable_latch_enable_s = sync2_q[6];
  wire [7:0] boe_s = sync2_q[14:7];
  wire [3:0] lb_s = sync2_q[18:15];
  wire [1:0] sel_s = sync2_q[20:19];
  // device reset pin starts low after rst_n, so device held in reset
  wire dev_rst = ~sync2_q[21];

  // enable latches, transparent while their enable is high
  logic [7:0] oe_q;
  logic [7:0] bist_q;
  logic [7:0] rx_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= slfr_pkg::OE_RST;
      bist_q <= slfr_pkg::BIST_RST;
      rx_q <= slfr_pkg::RX_RST;
    end else if (ce) begin
      if (dev_rst) begin
        oe_q <= slfr_pkg::OE_RST;
        bist_q <= slfr_pkg::BIST_RST;
        rx_q <= slfr_pkg::RX_RST;
      end else begin
        if (output_enable_latch_enable_s) oe_q <= boe_s;
        if (selftest_latch_enable_s) bist_q <= boe_s;
        if (receive_enable_latch_enable_s) rx_q <= boe_s;
      end
    end
  end

  // only even bits carry output and receive enables
  wire [3:0] oe_ch = {oe_q[6], oe_q[4], oe_q[2], oe_q[0]};
  wire [3:0] rx_en = {rx_q[6], rx_q[4], rx_q[2], rx_q[0]};

  // serial path
  logic [3:0] serial_q;
  logic [3:0] drive_q;
  logic [3:0] cdr_q;
  wire [3:0] serial_d = lb_s | tx_serial;
  wire [3:0] cdr_d = (lb_s & tx_serial) | (~lb_s & rx_s);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_q <= 4'hf;
      drive_q <= 4'h0;
      cdr_q <= 4'h0;
    end else if (ce) begin
      serial_q <= serial_d;
      drive_q <= oe_ch;
      cdr_q <= cdr_d;
    end
  end

  // transition density counters
  logic [7:0] dens_q;
  logic [7:0] run_q [NCH];
  logic [3:0] dens_low;
  logic [3:0] amp_low;
  wire [7:0] thr = amp_thr(sel_s);

  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    wire edge_seen = cdr_d[g] ^ cdr_q[g];
    wire sat = (run_q[g] == 8'hff);
    assign dens_low[g] = (run_q[g] >= dens_q);
    assign amp_low[g] = (rx_amplitude[g*8 +: 8] < thr);
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        run_q[g] <= 8'h0;
      end else if (ce) begin
        if (dev_rst || edge_seen) run_q[g] <= 8'h0;
        else if (!sat) run_q[g] <= run_q[g] + 8'h1;
      end
    end
  end

  wire [3:0] flt = freq_out_of_range | amp_low | dens_low | ~rx_en;

  // elasticity pointers, offset set on reset
  logic [2:0] eb_wr_q;
  logic [2:0] eb_rd_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eb_wr_q <= slfr_pkg::EB_NOMINAL;
      eb_rd_q <= 3'h0;
    end else if (ce) begin
      if (dev_rst) begin
        eb_wr_q <= slfr_pkg::EB_NOMINAL;
        eb_rd_q <= 3'h0;
      end else begin
        eb_wr_q <= eb_wr_q + 3'h1;
        eb_rd_q <= eb_rd_q + 3'h1;
      end
    end
  end

  // reset sequencing
  slfr_pkg::slfr_state_e state_q;
  slfr_pkg::slfr_state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic ready_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      slfr_pkg::ST_RESET: begin
        cnt_d = 4'h0;
        if (!dev_rst) state_d = slfr_pkg::ST_SETTLE;
      end
      slfr_pkg::ST_SETTLE: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == slfr_pkg::SETTLE_CYC - 4'h1) state_d = slfr_pkg::ST_RUN;
      end
      slfr_pkg::ST_RUN: begin
        cnt_d = 4'h0;
      end
      default: begin
        state_d = slfr_pkg::ST_RESET;
        cnt_d = 4'h0;
      end
    endcase
    if (dev_rst) state_d = slfr_pkg::ST_RESET;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= slfr_pkg::ST_RESET;
      cnt_q <= 4'h0;
      ready_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ready_q <= (state_d == slfr_pkg::ST_RUN);
    end
  end

  // fault output; held low while not yet settled
  logic [3:0] lfi_q;
  wire [3:0] lfi_d = ready_q ? ~flt : 4'h0;

  // registers and interrupt
  logic [3:0] status_q;
  logic [3:0] mask_q;
  logic irq_q;
  logic [31:0] rdata_q;
  wire wr_status = reg_wr && (reg_addr == slfr_pkg::REG_STATUS);
  wire wr_mask = reg_wr && (reg_addr == slfr_pkg::REG_MASK);
  wire wr_dens = reg_wr && (reg_addr == slfr_pkg::REG_DENSITY);
  wire [3:0] fault_rise = ~lfi_d & lfi_q;
  wire [3:0] clr = wr_status ? reg_wdata[3:0] : 4'h0;
  // set wins over a same-cycle clear
  wire [3:0] status_d = (status_q & ~clr) | fault_rise;
  wire [31:0] rd_mux =
    (reg_addr == slfr_pkg::REG_STATUS) ? {28'h0, status_q} :
    (reg_addr == slfr_pkg::REG_MASK) ? {28'h0, mask_q} :
    (reg_addr == slfr_pkg::REG_LATCH) ? {8'h0, rx_q, bist_q, oe_q} :
    (reg_addr == slfr_pkg::REG_DENSITY) ? {24'h0, dens_q} :
    (reg_addr == slfr_pkg::REG_STATE) ? {20'h0, lb_s, 4'h0, state_q, ready_q} :
    32'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lfi_q <= 4'h0;
      status_q <= 4'h0;
      mask_q <= slfr_pkg::MASK_RST;
      dens_q <= slfr_pkg::DENSITY_RST;
      irq_q <= 1'b0;
      rdata_q <= 32'h0;
    end else if (ce) begin
      lfi_q <= lfi_d;
      status_q <= status_d;
      if (wr_mask) mask_q <= reg_wdata[3:0];
      if (wr_dens) dens_q <= reg_wdata[7:0];
      irq_q <= |(status_d & mask_q);
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign serial_out = serial_q;
  assign serial_drive_en = drive_q;
  assign cdr_data = cdr_q;
  assign link_fault_n = lfi_q;
  assign selftest_enable_n = bist_q;
  assign rx_power_en = {rx_q[6], rx_q[4], rx_q[2], rx_q[0]};
  assign eb_wr_ptr = eb_wr_q;
  assign eb_rd_ptr = eb_rd_q;
  assign device_ready = ready_q;
  assign irq = irq_q;
  assign reg_rdata = rdata_q;

  // helper: enabled cycles since device reset release
  logic [4:0] rel_cnt_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rel_cnt_q <= 5'h0;
    else if (ce) begin
      if (dev_rst) rel_cnt_q <= 5'h0;
      else if (rel_cnt_q != 5'h1f) rel_cnt_q <= rel_cnt_q + 5'h1;
    end
  end

  sequence s_two_ce;
    ce ##1 ce;
  endsequence

  a_loop_output: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ce |=> ((serial_q & $past(lb_s)) == $past(lb_s)))
    else $error("loopback channel output not forced high");
  a_loop_route: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ce |=> (cdr_q & $past(lb_s)) == ($past(tx_serial) & $past(lb_s)))
    else $error("loopback receive not from transmit");
  // transmit held over the second cycle, so the captured bit must not move
  a_loop_ignore: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && lb_s == 4'hf) ##1 (ce && lb_s == 4'hf && $stable(tx_serial))
      |=> $stable(cdr_q))
    else $error("external input leaked in loopback");
  a_fault_or: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && ready_q) |=> lfi_q == ~$past(flt))
    else $error("link fault not or of conditions");
  a_amp_select: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && ready_q && sel_s == slfr_pkg::SEL_HIGH &&
     rx_amplitude[7:0] < slfr_pkg::AMP_HIGH) |=> !lfi_q[0])
    else $error("amplitude below high trip not flagged");
  // drivers follow the latch one cycle later
  a_reset_latch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && dev_rst) |=> (oe_q == slfr_pkg::OE_RST && rx_q == slfr_pkg::RX_RST
      && bist_q == slfr_pkg::BIST_RST ##1 drive_q == 4'h0))
    else $error("enable latches not reset");
  a_eb_offset: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && dev_rst) |=> (eb_wr_q - eb_rd_q) == slfr_pkg::EB_NOMINAL)
    else $error("buffer pointers not at nominal offset");
  a_ready_bound: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rel_cnt_q >= 5'h0f) |-> ready_q)
    else $error("not ready within 16 cycles");
  a_sync_depth: assert property (
    @(posedge mclk) disable iff (!rst_n)
    s_two_ce |=> lb_s == $past(loopback_enable, 2))
    else $error("loopback enable not two-stage synchronized");
  a_irq_level: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ce |=> irq_q == |($past(status_d) & $past(mask_q)))
    else $error("interrupt not masked status");

endmodule : slfr_top

// ---- dv/slfr_far_model.sv ----
/*
 remote transceiver model: amplitude, frequency flag, serial input.
 assumes the bench sets level and flags on mclk edges.
*/
`timescale 1ns/1ps
module slfr_far_model (
  // clock
  input wire logic mclk,
  // controls from bench
  input wire logic [7:0] amp_level,
  input wire logic [3:0] freq_bad,
  // serial side
  output logic [3:0] rx_serial_in,
  output logic [31:0] rx_amplitude,
  output logic [3:0] freq_out_of_range
);
  initial rx_serial_in = 4'h5;
  // live line keeps toggling, so a stale capture shows up
  always @(posedge mclk) rx_serial_in <= ~rx_serial_in;
  assign rx_amplitude = {4{amp_level}};
  assign freq_out_of_range = freq_bad;
endmodule : slfr_far_model

// ---- dv/slfr_top_tb.sv ----
/*
 self-checking bench for the link control block.
 assumes one 40 MHz clock; reads checked from a queue of notes.
*/
`timescale 1ns/1ps
module slfr_top_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic dev_rst_n = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [3:0] lb = 4'h0;
  logic [7:0] sh = 8'h00;
  logic oe_le = 1'b0;
  logic st_le = 1'b0;
  logic rx_le = 1'b0;
  logic [3:0] tx = 4'h0;
  logic [3:0] tx_h = 4'h0;
  logic [7:0] amp = 8'hff;
  logic [3:0] fbad = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_p = 1'b0;
  logic [7:0] lfsr = 8'h56;
  logic [3:0] rxs, fq, sout, sden, cdr, lfn, rxp;
  logic [31:0] ramp, rdata;
  logic [7:0] ste_n;
  logic [2:0] wp, rp;
  logic rdy, irq;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  always #12.5 mclk = ~mclk;
  slfr_far_model slfr_far_model_i (.mclk(mclk), .amp_level(amp), .freq_bad(fbad),
    .rx_serial_in(rxs), .rx_amplitude(ramp), .freq_out_of_range(fq));
  slfr_top slfr_top_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .device_reset_n(dev_rst_n),
    .detect_amplitude_select(sel), .loopback_enable(lb), .shared_enable_bits(sh),
    .output_enable_latch_enable(oe_le), .selftest_latch_enable(st_le),
    .receive_enable_latch_enable(rx_le), .tx_serial(tx), .rx_serial_in(rxs),
    .rx_amplitude(ramp), .freq_out_of_range(fq), .serial_out(sout), .serial_drive_en(sden),
    .cdr_data(cdr), .link_fault_n(lfn), .selftest_enable_n(ste_n), .rx_power_en(rxp),
    .eb_wr_ptr(wp), .eb_rd_ptr(rp), .device_ready(rdy), .irq(irq), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  function automatic logic [7:0] thr(input int i);
    thr = (i == 0) ? slfr_pkg::AMP_LOW : (i == 1) ? slfr_pkg::AMP_MID : slfr_pkg::AMP_HIGH;
  endfunction : thr
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: port %h expected %h", $time, got, exp);
    end
  endtask : cmp_port
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
  endtask : step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data are judged one cycle later by the monitor
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic lat(input logic [7:0] v, input logic o, input logic s, input logic r);
    @(posedge mclk);
    sh <= v;
    oe_le <= o;
    st_le <= s;
    rx_le <= r;
    step(5);
    oe_le <= 1'b0;
    st_le <= 1'b0;
    rx_le <= 1'b0;
    step(5);
  endtask : lat
  always @(posedge mclk) begin
    if (rd_p) cmp_reg(rdata, exp_q.pop_front());
    rd_p <= rd;
    lfsr <= lfsr_next(lfsr);
    tx <= lfsr[3:0];
    tx_h <= tx;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    step(10);
    rst_n <= 1'b1;
    step(6);
    cmp_port({rdy, lfn, wp, rp}, 32'h20);
    rd_reg(slfr_pkg::REG_LATCH, 32'h00ff00);
    rd_reg(slfr_pkg::REG_MASK, 32'h0);
    rd_reg(slfr_pkg::REG_DENSITY, 32'h3c);
    rd_reg(8'hfc, 32'h0);
    dev_rst_n <= 1'b1;
    for (n = 0; n < 16 && rdy !== 1'b1; n++) step(1);
    cmp_port(rdy, 32'h1);
    rd_reg(slfr_pkg::REG_STATE, 32'h9);
    lat(8'h55, 1'b1, 1'b1, 1'b1);
    rd_reg(slfr_pkg::REG_LATCH, 32'h555555);
    cmp_port({sden, rxp, ste_n}, 32'hff55);
    // first the plain path, then loopback with a toggling far line
    for (int m = 0; m < 2; m++) begin
      lb <= m[0] ? 4'hf : 4'h0;
      step(5);
      repeat (8) begin
        step(1);
        cmp_port(sout, m[0] ? 32'hf : tx_h);
        if (m == 1) cmp_port(cdr, tx_h);
        // three cycles behind a far line that toggles every cycle
        if (m == 0) cmp_port(cdr, {28'h0, ~rxs});
      end
    end
    cmp_port(lfn, 32'hf);
    for (int i = 0; i < 4; i++) begin
      sel <= i[1:0];
      amp <= thr(i) - 8'h01;
      step(6);
      cmp_port(lfn, 32'h0);
      amp <= thr(i);
      step(6);
      cmp_port(lfn, 32'hf);
    end
    wr_reg(slfr_pkg::REG_DENSITY, 32'h0);
    step(4);
    cmp_port(lfn, 32'h0);
    wr_reg(slfr_pkg::REG_DENSITY, 32'h3c);
    wr_reg(slfr_pkg::REG_STATUS, 32'hf);
    wr_reg(slfr_pkg::REG_MASK, 32'h1);
    fbad <= 4'h2;
    step(4);
    cmp_port({irq, lfn}, 32'h0d);
    rd_reg(slfr_pkg::REG_STATUS, 32'h2);
    fbad <= 4'h3;
    step(4);
    cmp_port(irq, 32'h1);
    fbad <= 4'h0;
    wr_reg(slfr_pkg::REG_STATUS, 32'h1);
    step(3);
    cmp_port(irq, 32'h0);
    rd_reg(slfr_pkg::REG_STATUS, 32'h2);
    lat(8'h15, 1'b0, 1'b0, 1'b1);
    cmp_port({rxp, lfn}, 32'h77);
    // frozen block must ignore a new fault until enabled again
    ce <= 1'b0;
    fbad <= 4'hf;
    step(4);
    cmp_port(lfn, 32'h7);
    ce <= 1'b1;
    step(3);
    cmp_port(lfn, 32'h0);
    fbad <= 4'h0;
    // second device reset in mid-run
    dev_rst_n <= 1'b0;
    step(5);
    rd_reg(slfr_pkg::REG_LATCH, 32'h00ff00);
    cmp_port({sden, rxp, wp, rp}, 32'h20);
    rd_reg(slfr_pkg::REG_STATE, 32'hf02);
    step(2);
    end_of_test();
  end
endmodule : slfr_top_tb
